// [stop_wake_and_voltage_monitor.sv]
// Stop-mode wake selection and supply-voltage monitor with APB registers.
//
// Functional notes
// - Wake-source field picks pin combination, resets zero.
// - Output-configured port 0 and port 2 pins never join wake logic.
// - Monitoring runs only while enable bit set.
// - Flags hidden until 20 us after enabling.
// - Bit 2 shows high-supply flag.
// - Bit 1 shows low-supply flag.
// - Enabled low flag raises low-supply interrupt request.
// - Request bit latches until cleared or reset.
// - Mask gates request onto interrupt output.
`timescale 1ns/1ns
`default_nettype none
`include "supply_monitor_map.svh"
module stop_wake_and_voltage_monitor
   import supply_monitor_pkg::*;
#(
   parameter int SETTLE_CYCLES = `SUPPLY_SETTLE_CYCLES
) (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // Port pin levels and their direction (1 = pin is an output).
   input  wire logic [7:0]  port0_in,
   input  wire logic [7:0]  port0_is_output,
   input  wire logic [7:0]  port2_in,
   input  wire logic [7:0]  port2_is_output,
   input  wire logic [7:0]  port3_in,
   // Analog comparator outputs, asynchronous.
   input  wire logic        supply_above_high,
   input  wire logic        supply_below_low,
   // Outputs to the power and interrupt logic.
   output var  logic        stop_wake,
   output var  logic        supply_monitor_enable,
   output var  logic        supply_monitor_settled,
   output var  logic        irq
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

   logic             vd_enable;         // Monitor enable bit.
   logic             next_vd_enable;
   logic             wake_level;        // Active level of the wake condition.
   logic             next_wake_level;
   wake_source_e     wake_source;       // Selected wake combination.
   wake_source_e     next_wake_source;
   logic [7:0]       irq_status;        // Sticky interrupt requests.
   logic [7:0]       next_irq_status;
   logic [7:0]       irq_mask;          // Interrupt enables.
   logic [7:0]       next_irq_mask;
   monitor_state_e   mon_state;         // Settling state of the monitor.
   monitor_state_e   next_mon_state;
   logic [CNT_W-1:0] settle_cnt;        // Cycles left before flags are valid.
   logic [CNT_W-1:0] next_settle_cnt;
   logic             high_flag;         // Published high-supply flag.
   logic             next_high_flag;
   logic             low_flag;          // Published low-supply flag.
   logic             next_low_flag;
   logic [31:0]      next_prdata;
   logic             next_pready;
   logic             next_pslverr;
   logic             next_stop_wake;
   logic             next_irq;
   logic             above_sync;        // Synchronised high comparator.
   logic             below_sync;        // Synchronised low comparator.
   logic             setup_phase;       // APB setup cycle seen.
   logic             write_done;        // Write completes at this edge.
   logic             read_done;         // Read completes at this edge.
   logic             addr_ok;           // Address hits a register.
   logic             wake_raw;          // Combined wake condition before level.

   // ****************************************************************
   // Comparator synchronisers
   // ****************************************************************
   // synchronise comparator levels
   sync_two_flop u_sync_above (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (supply_above_high),
      .sync_out (above_sync)
   );

   sync_two_flop u_sync_below (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (supply_below_low),
      .sync_out (below_sync)
   );

   // ****************************************************************
   // APB decode
   // ****************************************************************
   // The slave answers in the first access cycle: pready is a flop that is
   // loaded during setup, which costs nothing and keeps outputs registered.
   always_comb begin
      setup_phase = psel && !penable;
      write_done  = psel && penable && pready && pwrite;
      read_done   = psel && penable && pready && !pwrite;
      addr_ok     = (paddr == `VD_CTRL_ADDR)    || (paddr == `WAKE_CTRL_ADDR) ||
                    (paddr == `IRQ_STATUS_ADDR) || (paddr == `IRQ_MASK_ADDR);
   end

   // Read data and answer are prepared in setup and held through access.
   always_comb begin
      next_prdata  = prdata;
      next_pready  = 1'b0;
      next_pslverr = 1'b0;
      if (setup_phase) begin
         next_pready  = 1'b1;
         next_pslverr = !addr_ok;
         next_prdata  = 32'h0000_0000;
         if (!pwrite) begin
            unique case (paddr)
               `VD_CTRL_ADDR: begin
                  next_prdata[`VD_HIGH_FLAG_BIT:`VD_ENABLE_BIT] = {high_flag, low_flag, vd_enable};
               end
               // The wake control register is write only and reads as zero.
               `IRQ_STATUS_ADDR: next_prdata[7:0] = irq_status;
               `IRQ_MASK_ADDR:   next_prdata[7:0] = irq_mask;
               default:          next_prdata = 32'h0000_0000;
            endcase
         end
      end else if (psel && penable && !pready) begin
         next_pready  = 1'b1;
         next_pslverr = pslverr;
      end
   end

   // Bus answer registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ****************************************************************
   // Control registers
   // ****************************************************************
   // Writes take effect at the access edge; reserved bits are dropped.
   always_comb begin
      next_vd_enable   = vd_enable;
      next_wake_level  = wake_level;
      next_wake_source = wake_source;
      next_irq_mask    = irq_mask;
      if (write_done) begin
         unique case (paddr)
            `VD_CTRL_ADDR: begin
               next_vd_enable = pwdata[`VD_ENABLE_BIT];
            end
            `WAKE_CTRL_ADDR: begin
               next_wake_level  = pwdata[`WAKE_LEVEL_BIT];
               next_wake_source = wake_source_e'(pwdata[`WAKE_SRC_MSB:`WAKE_SRC_LSB]);
            end
            `IRQ_MASK_ADDR: begin
               next_irq_mask = pwdata[7:0];
            end
            default: next_irq_mask = irq_mask;
         endcase
      end
   end

   // Control flops clear to their reset values.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vd_enable   <= 1'(`VD_CTRL_RESET >> `VD_ENABLE_BIT);
         wake_level  <= 1'b0;
         wake_source <= WAKE_POR_ONLY;
         irq_mask    <= `IRQ_MASK_RESET;
      end else begin
         vd_enable   <= next_vd_enable;
         wake_level  <= next_wake_level;
         wake_source <= next_wake_source;
         irq_mask    <= next_irq_mask;
      end
   end

   // ****************************************************************
   // Supply monitor and flags
   // ****************************************************************
   // The comparators need time to settle, so the flags stay clear until the
   // settling count has run out; a disable restarts the whole wait.
   always_comb begin
      next_mon_state  = mon_state;
      next_settle_cnt = settle_cnt;
      next_high_flag  = 1'b0;
      next_low_flag   = 1'b0;
      unique case (mon_state)
         MON_OFF: begin
            if (vd_enable) begin
               next_mon_state  = MON_SETTLING;
               next_settle_cnt = CNT_W'(SETTLE_CYCLES - 1);
            end
         end
         MON_SETTLING: begin
            if (!vd_enable) begin
               next_mon_state = MON_OFF;
            end else if (settle_cnt == '0) begin
               next_mon_state = MON_ACTIVE;
            end else begin
               next_settle_cnt = settle_cnt - 1'b1;
            end
         end
         MON_ACTIVE: begin
            if (!vd_enable) begin
               next_mon_state = MON_OFF;
            end else begin
               next_high_flag = above_sync;
               next_low_flag  = below_sync;
            end
         end
      endcase
   end

   // Monitor state and flags.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mon_state  <= MON_OFF;
         settle_cnt <= '0;
         high_flag  <= 1'b0;
         low_flag   <= 1'b0;
      end else begin
         mon_state  <= next_mon_state;
         settle_cnt <= next_settle_cnt;
         high_flag  <= next_high_flag;
         low_flag   <= next_low_flag;
      end
   end

   // ****************************************************************
   // Interrupt request and mask
   // ****************************************************************
   // A read clears only the bits it returned, and a new event wins over the
   // clear, so no low-supply event is lost between setup and access.
   always_comb begin
      next_irq_status = irq_status;
      if (read_done && (paddr == `IRQ_STATUS_ADDR)) begin
         next_irq_status = irq_status & ~prdata[7:0];
      end
      if (vd_enable && low_flag) begin
         next_irq_status[`LOW_SUPPLY_IRQ_BIT] = 1'b1;
      end
      next_irq = |(next_irq_status & irq_mask);
   end

   // Interrupt flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= `IRQ_STATUS_RESET;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq        <= next_irq;
      end
   end

   // ****************************************************************
   // Stop-mode wake logic
   // ****************************************************************
   // Excluded pins are forced to the neutral value of their gate: one for a
   // NAND and zero for a NOR, so they can neither cause nor block a wake.
   always_comb begin
      logic [7:0] p0_nand;
      logic [7:0] p0_nor;
      logic [7:0] p2_nand;
      logic [2:0] p3;
      p0_nand = port0_in | port0_is_output;
      p0_nor  = port0_in & ~port0_is_output;
      p2_nand = port2_in | port2_is_output;
      p3      = port3_in[3:1];
      unique case (wake_source)
         WAKE_POR_ONLY:    wake_raw = 1'b0;
         WAKE_NAND_P2_LOW: wake_raw = ~&p2_nand[3:0];
         WAKE_NAND_P2_ALL: wake_raw = ~&p2_nand;
         WAKE_NOR_P3:      wake_raw = ~|p3;
         WAKE_NAND_P3:     wake_raw = ~&p3;
         WAKE_NOR_P3_P0:   wake_raw = ~|{p3, p0_nor[0], p0_nor[7]};
         WAKE_NAND_P3_P0:  wake_raw = ~&{p3, p0_nand[0], p0_nand[7]};
         WAKE_NAND_P3_P2:  wake_raw = ~&{p3, p2_nand[2:0]};
      endcase
      next_stop_wake = (wake_source != WAKE_POR_ONLY) && (wake_raw == wake_level);
   end

   // Wake and monitor status outputs.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_wake              <= 1'b0;
         supply_monitor_enable  <= 1'b0;
         supply_monitor_settled <= 1'b0;
      end else begin
         stop_wake              <= next_stop_wake;
         supply_monitor_enable  <= next_vd_enable;
         // Settled rises on the same edge as the first valid flags, never before.
         supply_monitor_settled <= (mon_state == MON_ACTIVE) && vd_enable;
      end
   end

endmodule
`default_nettype wire

// [stop_wake_and_voltage_monitor_asserts.sv]
// Concurrent checks on the ports of the stop-wake and supply monitor block.
`timescale 1ns/1ns
`default_nettype none
`include "supply_monitor_map.svh"
module swvm_checker #(
   parameter int SETTLE_CYCLES = `SUPPLY_SETTLE_CYCLES
) (
   // Clock, reset and APB.
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   // Monitor inputs and outputs.
   input wire logic        supply_below_low,
   input wire logic        stop_wake,
   input wire logic        supply_monitor_enable,
   input wire logic        supply_monitor_settled,
   input wire logic        irq
);
   // ****************************************************************
   // Helper state mirrored from completed bus writes
   // ****************************************************************
   logic acc;      // A transfer completes in this cycle.
   logic mask_on;  // Mirror of the low-supply mask bit.
   logic src_zero; // Mirror: wake source is the reset-only code.
   int   en_cnt;   // Cycles the monitor has been enabled, saturating.
   assign acc = psel && penable && pready;
   // The mirrors update on the same edge at which the design takes a write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_on  <= 1'b0;
         src_zero <= 1'b1;
         en_cnt   <= 0;
      end else begin
         if (acc && pwrite && paddr == `IRQ_MASK_ADDR) begin
            mask_on <= pwdata[`LOW_SUPPLY_IRQ_BIT];
         end
         if (acc && pwrite && paddr == `WAKE_CTRL_ADDR) begin
            src_zero <= (pwdata[4:2] == 3'h0);
         end
         // Saturate so the counter never wraps during long enables.
         if (!supply_monitor_enable) begin
            en_cnt <= 0;
         end else if (en_cnt < SETTLE_CYCLES + 8) begin
            en_cnt <= en_cnt + 1;
         end
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_enable_copy;
      acc && pwrite && paddr == `VD_CTRL_ADDR |=> supply_monitor_enable == $past(pwdata[0]);
   endproperty
   a_enable_copy: assert property (p_enable_copy) else $error("enable bit not copied");
   property p_off_unsettled;
      !supply_monitor_enable && !$past(supply_monitor_enable) |-> !supply_monitor_settled;
   endproperty
   a_off_unsettled: assert property (p_off_unsettled) else $error("settled while off");
   property p_settle_min;
      supply_monitor_enable && supply_monitor_settled |-> en_cnt >= SETTLE_CYCLES - 2;
   endproperty
   a_settle_min: assert property (p_settle_min) else $error("settled too early");
   property p_settle_max;
      supply_monitor_enable && en_cnt == SETTLE_CYCLES + 4 |-> supply_monitor_settled;
   endproperty
   a_settle_max: assert property (p_settle_max) else $error("settled too late");
   property p_high_hidden;
      acc && !pwrite && paddr == `VD_CTRL_ADDR && !supply_monitor_settled |-> !prdata[2];
   endproperty
   a_high_hidden: assert property (p_high_hidden) else $error("high flag before settle");
   property p_low_hidden;
      acc && !pwrite && paddr == `VD_CTRL_ADDR && !supply_monitor_settled |-> !prdata[1];
   endproperty
   a_low_hidden: assert property (p_low_hidden) else $error("low flag before settle");
   property p_low_raises;
      (supply_monitor_settled && mask_on && supply_below_low) [*5] |-> ##[0:3] irq;
   endproperty
   a_low_raises: assert property (p_low_raises) else $error("low supply gave no irq");
   property p_request_held;
      irq && !(acc && !pwrite && paddr == `IRQ_STATUS_ADDR)
          && !(acc && pwrite && paddr == `IRQ_MASK_ADDR) |=> irq;
   endproperty
   a_request_held: assert property (p_request_held) else $error("request dropped");
   property p_mask_gates;
      !mask_on && !$past(mask_on) |-> !irq;
   endproperty
   a_mask_gates: assert property (p_mask_gates) else $error("irq while masked");
   property p_por_only;
      src_zero && $past(src_zero) |-> !stop_wake;
   endproperty
   a_por_only: assert property (p_por_only) else $error("wake with reset-only source");
endmodule
bind stop_wake_and_voltage_monitor swvm_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) swvm_checker_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .supply_below_low(supply_below_low), .stop_wake(stop_wake),
   .supply_monitor_enable(supply_monitor_enable),
   .supply_monitor_settled(supply_monitor_settled), .irq(irq));
`default_nettype wire

// [stop_wake_and_voltage_monitor_tb.sv]
// Self-checking bench for the stop-wake and supply monitor block.
`timescale 1ns/1ns
`default_nettype none
`include "supply_monitor_map.svh"
module stop_wake_and_voltage_monitor_tb
   import supply_monitor_pkg::*;
;
   localparam int SET = 4; // Short settle count keeps the run brief.
   // Pin vectors {port0, port0 dir, port2, port2 dir, port3}; rows 3 and 4 exclude pins.
   localparam logic [39:0] VEC [5] = '{40'h0000000000, 40'hFF00FF00FF, 40'h01000F000A,
                                       40'h008100FF00, 40'hFF81FFFF00};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  port0_in, port0_is_output, port2_in, port2_is_output, port3_in;
   logic        supply_above_high, supply_below_low, stop_wake;
   logic        supply_monitor_enable, supply_monitor_settled, irq;
   int          n_fail = 0;
   int          n_tests = 0;
   stop_wake_and_voltage_monitor #(.SETTLE_CYCLES(SET)) stop_wake_and_voltage_monitor_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port0_in(port0_in), .port0_is_output(port0_is_output), .port2_in(port2_in),
      .port2_is_output(port2_is_output), .port3_in(port3_in),
      .supply_above_high(supply_above_high), .supply_below_low(supply_below_low),
      .stop_wake(stop_wake), .supply_monitor_enable(supply_monitor_enable),
      .supply_monitor_settled(supply_monitor_settled), .irq(irq));
   // ****************************************************************
   // Compare, bus and scenario tasks
   // ****************************************************************
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: bit got %b expected %b", $time, got, exp);
      end
   endtask
   // One APB transfer; the request is held until pready is seen at an edge.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      chk1(pready, 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      xfer(1'b1, a, d, r, e);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] r;
      logic        e;
      xfer(1'b0, a, 32'h0, r, e);
      chk32(r, exp);
      chk1(e, experr);
   endtask
   // Bounded wait for the flags to become valid.
   task automatic wait_settled;
      int n;
      n = 0;
      while (supply_monitor_settled !== 1'b1 && n < SET + 20) begin
         @(posedge pclk);
         n++;
      end
      chk1(supply_monitor_settled, 1'b1);
   endtask
   // Expected wake level; an excluded pin reads 1 for NAND and 0 for NOR.
   function automatic logic wexp(input logic [2:0] s, input logic lv, input logic [39:0] v);
      logic [7:0] a0, o0, a2, o2, a3, n0, n2, r0;
      logic       c;
      {a0, o0, a2, o2, a3} = v;
      n0 = a0 | o0;
      n2 = a2 | o2;
      r0 = a0 & ~o0;
      case (s)
         WAKE_NAND_P2_LOW: c = ~&n2[3:0];
         WAKE_NAND_P2_ALL: c = ~&n2;
         WAKE_NOR_P3:      c = ~|a3[3:1];
         WAKE_NAND_P3:     c = ~&a3[3:1];
         WAKE_NOR_P3_P0:   c = ~|{a3[3:1], r0[0], r0[7]};
         WAKE_NAND_P3_P0:  c = ~&{a3[3:1], n0[0], n0[7]};
         WAKE_NAND_P3_P2:  c = ~&{a3[3:1], n2[2:0]};
         default:          c = ~lv;
      endcase
      return c == lv;
   endfunction
   task automatic t_reset;
      rdc(`VD_CTRL_ADDR, 32'h0, 1'b0);
      rdc(`IRQ_STATUS_ADDR, 32'h0, 1'b0);
      rdc(`IRQ_MASK_ADDR, 32'h0, 1'b0);
      rdc(`WAKE_CTRL_ADDR, 32'h0, 1'b0);
      rdc(12'h100, 32'h0, 1'b1);
      chk1(stop_wake, 1'b0);
      $display("reset test done");
   endtask
   task automatic t_monitor;
      supply_above_high <= 1'b1;
      supply_below_low  <= 1'b1;
      wr(`IRQ_MASK_ADDR, 32'h20);
      wr(`VD_CTRL_ADDR, 32'h01);
      repeat (SET - 2) @(posedge pclk);
      #1;
      chk1(supply_monitor_settled, 1'b0);
      chk1(irq, 1'b0);
      wait_settled;
      repeat (6) @(posedge pclk);
      rdc(`VD_CTRL_ADDR, 32'h07, 1'b0);
      chk1(irq, 1'b1);
      supply_above_high <= 1'b0;
      supply_below_low  <= 1'b0;
      repeat (6) @(posedge pclk);
      rdc(`VD_CTRL_ADDR, 32'h01, 1'b0);
      chk1(irq, 1'b1);
      rdc(`IRQ_STATUS_ADDR, 32'h20, 1'b0);
      repeat (2) @(posedge pclk);
      #1;
      chk1(irq, 1'b0);
      rdc(`IRQ_STATUS_ADDR, 32'h0, 1'b0);
      wr(`VD_CTRL_ADDR, 32'h0);
      repeat (3) @(posedge pclk);
      #1;
      chk1(supply_monitor_enable, 1'b0);
      rdc(`VD_CTRL_ADDR, 32'h0, 1'b0);
      $display("monitor test done");
   endtask
   task automatic t_mask;
      wr(`IRQ_MASK_ADDR, 32'h0);
      supply_below_low <= 1'b1;
      wr(`VD_CTRL_ADDR, 32'h01);
      wait_settled;
      repeat (8) @(posedge pclk);
      #1;
      chk1(irq, 1'b0);
      @(posedge pclk);
      supply_below_low <= 1'b0;
      repeat (4) @(posedge pclk);
      rdc(`IRQ_STATUS_ADDR, 32'h20, 1'b0);
      wr(`VD_CTRL_ADDR, 32'h0);
      $display("mask test done");
   endtask
   task automatic t_wake;
      int s, lv, k;
      for (s = 0; s < 8; s++) begin
         for (lv = 0; lv < 2; lv++) begin
            wr(`WAKE_CTRL_ADDR, {25'h0, lv[0], 1'b0, s[2:0], 2'b00});
            for (k = 0; k < 5; k++) begin
               @(posedge pclk);
               {port0_in, port0_is_output, port2_in, port2_is_output, port3_in} <= VEC[k];
               repeat (4) @(posedge pclk);
               #1;
               chk1(stop_wake, wexp(s[2:0], lv[0], VEC[k]));
            end
         end
      end
      $display("wake test done");
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // Main sequence: inputs are quiet at time zero and reset spans 12 cycles.
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      {port0_in, port0_is_output, port2_in, port2_is_output, port3_in} = 40'h0;
      supply_above_high = 1'b0;
      supply_below_low = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_monitor;
      t_mask;
      t_wake;
      complete_run;
   end
   // Watchdog well beyond the expected run of about 550 cycles.
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      complete_run;
   end
endmodule
`default_nettype wire

// [supply_monitor_map.svh]
// Register offsets, field positions, reset values and timing counts of the supply monitor.
`ifndef SUPPLY_MONITOR_MAP_SVH
`define SUPPLY_MONITOR_MAP_SVH

// ****************************************************************
// Register indices and byte addresses
// ****************************************************************
`define VD_CTRL_INDEX        8'h0C
`define WAKE_CTRL_INDEX      8'h0D
`define IRQ_STATUS_INDEX     8'h0E
`define IRQ_MASK_INDEX       8'h0F
`define VD_CTRL_ADDR         12'h030
`define WAKE_CTRL_ADDR       12'h034
`define IRQ_STATUS_ADDR      12'h038
`define IRQ_MASK_ADDR        12'h03C

// ****************************************************************
// Field positions
// ****************************************************************
`define VD_ENABLE_BIT        0
`define VD_LOW_FLAG_BIT      1
`define VD_HIGH_FLAG_BIT     2
`define WAKE_LEVEL_BIT       6
`define WAKE_SRC_MSB         4
`define WAKE_SRC_LSB         2
`define LOW_SUPPLY_IRQ_BIT   5

// ****************************************************************
// Reset values
// ****************************************************************
`define VD_CTRL_RESET        8'h00
`define WAKE_CTRL_RESET      8'h00
`define IRQ_STATUS_RESET     8'h00
`define IRQ_MASK_RESET       8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define PCLK_PERIOD_NS       50
`define SUPPLY_SETTLE_NS     20000
`define SUPPLY_SETTLE_CYCLES ((`SUPPLY_SETTLE_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)

`endif

// [supply_monitor_pkg.sv]
// Types shared by the stop-wake and supply monitor logic.
package supply_monitor_pkg;

   // Wake-source selections of the stop-wake control field.
   typedef enum logic [2:0] {
      WAKE_POR_ONLY     = 3'h0,
      WAKE_NAND_P2_LOW  = 3'h1,
      WAKE_NAND_P2_ALL  = 3'h2,
      WAKE_NOR_P3       = 3'h3,
      WAKE_NAND_P3      = 3'h4,
      WAKE_NOR_P3_P0    = 3'h5,
      WAKE_NAND_P3_P0   = 3'h6,
      WAKE_NAND_P3_P2   = 3'h7
   } wake_source_e;

   // Life cycle of the supply monitor after it is enabled.
   typedef enum logic [1:0] {
      MON_OFF,
      MON_SETTLING,
      MON_ACTIVE
   } monitor_state_e;

endpackage

// [sync_two_flop.sv]
// Two-flop synchroniser for one asynchronous level.
`timescale 1ns/1ns
`default_nettype none
module sync_two_flop (
   // Clock and reset.
   input  wire logic pclk,
   input  wire logic presetn,
   // Asynchronous level in, synchronous level out.
   input  wire logic async_in,
   output var  logic sync_out
);

   // First stage; only the second stage reads it.
   logic meta;

   // Both stages clear to a constant under reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta     <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule
`default_nettype wire
